// [hdl/uism_map.svh]
`ifndef UISM_MAP_SVH
`define UISM_MAP_SVH
// ---------------------------------------------------------------
// register byte offsets
// ---------------------------------------------------------------
`define UISM_OFF_INCHG    12'h000
`define UISM_OFF_AUXCTL   12'h004
`define UISM_OFF_ISTAT    12'h008
`define UISM_OFF_IMASK    12'h00C
`define UISM_OFF_BAUDH    12'h010
`define UISM_OFF_BAUDL    12'h014
`define UISM_OFF_IVEC     12'h018
`define UISM_OFF_INPORT   12'h01C
`define UISM_OFF_HSSET    12'h020
`define UISM_OFF_HSCLR    12'h024
`define UISM_OFF_PRELOAD  12'h028
// ---------------------------------------------------------------
// field positions and reset values
// ---------------------------------------------------------------
`define UISM_BIT_COS      7
`define UISM_BIT_DB       2
`define UISM_BIT_RX       1
`define UISM_BIT_TX       0
`define UISM_BIT_IEC      0
`define UISM_BIT_RF       6
`define UISM_BIT_INCOS    4
`define UISM_INCHG_ONES   8'h0E
`define UISM_IVEC_RST     8'h0F
`define UISM_PRELOAD_MIN  16'h0002
// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define UISM_FILT_NS      25000
`define UISM_CLK_NS       40
`define UISM_FILT_CYC     ((`UISM_FILT_NS + `UISM_CLK_NS - 1) / `UISM_CLK_NS)
`define UISM_SETTLE_SCLK  2
`endif

// [hdl/uism_pkg.sv]
package uism_pkg;
	// live channel status seen from receiver and transmitter
	typedef struct packed {
		logic breakEdge;
		logic fifoFull;
		logic rxReady;
		logic txReady;
	} uism_chan_t;
	// start-up tracking of the handshake input
	typedef enum logic [1:0] {
		UISM_WAIT  = 2'b00,
		UISM_TRACK = 2'b01
	} uism_state_t;
endpackage : uism_pkg

// [hdl/uism_core.sv]
`timescale 1ns/10ps
`default_nettype none
`include "uism_map.svh"
module uism_core
	import uism_pkg::*;
#(
	parameter int FILT_CYC = `UISM_FILT_CYC
) (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        rst_n,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// channel side
	input  wire logic        serialTick,
	input  wire uism_chan_t  chanIn,
	input  wire logic        firstModeRf,
	input  wire logic        breakReset,
	// pins and results
	input  wire logic        ctsPin,
	output logic             rtsPin_n,
	output logic             irqOut,
	output logic      [7:0]  irqVector,
	output logic      [15:0] baudPreload,
	output logic      [7:0]  auxControl
);
	// ---------------------------------------------------------------
	// reset release
	// ---------------------------------------------------------------
	logic [1:0] rstSync_q;
	logic       rstI_n;
	// async assert, synchronous release through two stages
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) rstSync_q <= 2'b00;
		else rstSync_q <= {rstSync_q[0], 1'b1};
	end
	assign rstI_n = rstSync_q[1];

	// ---------------------------------------------------------------
	// bus decode
	// ---------------------------------------------------------------
	logic acc, wr, rd, hit;
	assign acc = psel & penable & pready;
	assign wr  = acc & pwrite;
	assign rd  = acc & ~pwrite;
	always_comb begin
		case (paddr)
			`UISM_OFF_INCHG, `UISM_OFF_AUXCTL, `UISM_OFF_ISTAT,
			`UISM_OFF_IMASK, `UISM_OFF_BAUDH, `UISM_OFF_BAUDL,
			`UISM_OFF_IVEC, `UISM_OFF_INPORT, `UISM_OFF_HSSET,
			`UISM_OFF_HSCLR, `UISM_OFF_PRELOAD: hit = 1'b1;
			default: hit = 1'b0;
		endcase
	end

	// ---------------------------------------------------------------
	// cts filter and change detect
	// ---------------------------------------------------------------
	uism_state_t st_q, st_d;
	logic        sclk_q, sclk_d;
	logic        cts_q, cts_d;
	logic [15:0] filt_q, filt_d;
	logic        cosEvt;
	always_comb begin
		st_d   = st_q;
		sclk_d = sclk_q;
		cts_d  = cts_q;
		filt_d = filt_q;
		cosEvt = 1'b0;
		case (st_q)
			UISM_WAIT: begin
				// settle two serial clocks, then adopt pin
				if (serialTick) begin
					if (sclk_q) begin
						st_d  = UISM_TRACK;
						cts_d = ctsPin;
						cosEvt = ~ctsPin; // asserted is low
					end
					sclk_d = 1'b1;
				end
			end
			UISM_TRACK: begin
				// level must differ for the full filter time
				if (ctsPin == cts_q) filt_d = 16'h0000;
				else if (filt_q == 16'(FILT_CYC - 1)) begin
					filt_d = 16'h0000;
					cts_d  = ctsPin;
					cosEvt = 1'b1;
				end else filt_d = filt_q + 16'h0001;
			end
			default: st_d = UISM_WAIT;
		endcase
	end
	always_ff @(posedge clk or negedge rstI_n) begin
		if (!rstI_n) begin
			st_q   <= UISM_WAIT;
			sclk_q <= 1'b0;
			cts_q  <= 1'b1;
			filt_q <= 16'h0000;
		end else begin
			st_q   <= st_d;
			sclk_q <= sclk_d;
			cts_q  <= cts_d;
			filt_q <= filt_d;
		end
	end

	// ---------------------------------------------------------------
	// software registers and sticky flags
	// ---------------------------------------------------------------
	logic       cos_q, cos_d, scos_q, scos_d, db_q, db_d;
	logic [7:0] aux_q, aux_d, mask_q, mask_d, vec_q, vec_d;
	logic [7:0] bh_q, bh_d, bl_q, bl_d;
	logic       rts_q, rts_d;
	logic       rdInchg;
	assign rdInchg = rd & (paddr == `UISM_OFF_INCHG);
	always_comb begin
		aux_d  = aux_q;
		mask_d = mask_q;
		vec_d  = vec_q;
		bh_d   = bh_q;
		bl_d   = bl_q;
		rts_d  = rts_q;
		// read clears, a new change wins over it
		cos_d  = cosEvt | (cos_q & ~rdInchg);
		// status copy only when input enable set
		scos_d = (cosEvt & aux_q[`UISM_BIT_IEC]) | (scos_q & ~rdInchg);
		// break edge sets, command clears, set wins
		db_d   = chanIn.breakEdge | (db_q & ~breakReset);
		if (wr) begin
			case (paddr)
				`UISM_OFF_AUXCTL: aux_d  = pwdata[7:0];
				`UISM_OFF_IMASK:  mask_d = pwdata[7:0];
				`UISM_OFF_IVEC:   vec_d  = pwdata[7:0];
				`UISM_OFF_BAUDH:  bh_d   = pwdata[7:0];
				`UISM_OFF_BAUDL:  bl_d   = pwdata[7:0];
				// set address: ones assert only
				`UISM_OFF_HSSET:  if (pwdata[0]) rts_d = 1'b1;
				// clear address: ones negate only
				`UISM_OFF_HSCLR:  if (pwdata[0]) rts_d = 1'b0;
				default: ;
			endcase
		end
	end
	always_ff @(posedge clk or negedge rstI_n) begin
		if (!rstI_n) begin
			cos_q  <= 1'b0;
			scos_q <= 1'b0;
			db_q   <= 1'b0;
			aux_q  <= 8'h00;
			mask_q <= 8'h00;
			vec_q  <= `UISM_IVEC_RST;
			bh_q   <= 8'h00;
			bl_q   <= 8'h00;
			rts_q  <= 1'b0;
		end else begin
			cos_q  <= cos_d;
			scos_q <= scos_d;
			db_q   <= db_d;
			aux_q  <= aux_d;
			mask_q <= mask_d;
			vec_q  <= vec_d;
			bh_q   <= bh_d;
			bl_q   <= bl_d;
			rts_q  <= rts_d;
		end
	end

	// ---------------------------------------------------------------
	// status assembly and interrupt
	// ---------------------------------------------------------------
	logic [7:0] stat;
	always_comb begin
		stat = 8'h00;
		stat[`UISM_BIT_COS] = scos_q;
		stat[`UISM_BIT_DB]  = db_q;
		// receive bit follows mode selection
		stat[`UISM_BIT_RX]  = firstModeRf ? chanIn.fifoFull : chanIn.rxReady;
		// live copy; holding-register gating lives in the transmitter
		stat[`UISM_BIT_TX]  = chanIn.txReady;
	end

	// ---------------------------------------------------------------
	// bus answer and outputs
	// ---------------------------------------------------------------
	logic [31:0] rdat_d, prdata_q;
	logic        irq_d, irq_q, rdy_q, err_q, err_d;
	always_comb begin
		rdat_d = 32'h0000_0000;
		case (paddr)
			`UISM_OFF_INCHG: begin
				rdat_d[7:0] = `UISM_INCHG_ONES;
				rdat_d[`UISM_BIT_INCOS] = cos_q;
				rdat_d[0] = ctsPin;
			end
			`UISM_OFF_AUXCTL: rdat_d[7:0] = aux_q;
			`UISM_OFF_ISTAT:  rdat_d[7:0] = stat; // unmasked
			`UISM_OFF_IMASK:  rdat_d[7:0] = mask_q;
			`UISM_OFF_IVEC:   rdat_d[7:0] = vec_q;
			// pin level at the read, same as change bit 0
			`UISM_OFF_INPORT: rdat_d[0]   = ctsPin;
			// preload bytes are write only, read zero
			default: rdat_d = 32'h0000_0000;
		endcase
		err_d = psel & ~penable & ~hit;
		// level, held while any unmasked flag stays set
		irq_d = |(stat & mask_q);
	end
	always_ff @(posedge clk or negedge rstI_n) begin
		if (!rstI_n) begin
			prdata_q <= 32'h0000_0000;
			rdy_q    <= 1'b0;
			err_q    <= 1'b0;
			irq_q    <= 1'b0;
		end else begin
			// no wait state: answer registered in setup
			prdata_q <= (psel & ~penable) ? rdat_d : 32'h0000_0000;
			rdy_q    <= psel & ~penable;
			err_q    <= err_d;
			irq_q    <= irq_d;
		end
	end
	assign prdata      = prdata_q;
	assign pready      = rdy_q;
	assign pslverr     = err_q & rdy_q;
	assign irqOut      = irq_q;
	assign rtsPin_n    = ~rts_q; // inverted at pin
	assign irqVector   = vec_q;
	assign baudPreload = {bh_q, bl_q}; // high then low byte
	assign auxControl  = aux_q;
endmodule : uism_core
`default_nettype wire

// [testbench/uism_checker.sv]
`timescale 1ns/10ps
`default_nettype none
`include "uism_map.svh"
// ------------------------------
// port checks of the status block
// ------------------------------
module uism_checker (
	// clock, reset and bus
	input wire logic        clk,
	input wire logic        rst_n,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	// register results
	input wire logic        rtsPin_n,
	input wire logic [7:0]  irqVector,
	input wire logic [15:0] baudPreload,
	input wire logic [7:0]  auxControl
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	// a write or read takes effect only at this edge
	logic wrDone;
	logic rdDone;
	assign wrDone = psel && penable && pready && pwrite;
	assign rdDone = psel && penable && pready && !pwrite;
	property p_rtsSet;
		wrDone && paddr == `UISM_OFF_HSSET && pwdata[0] |=> !rtsPin_n;
	endproperty
	a_rtsSet: assert property (p_rtsSet)
		else $error("handshake output not asserted");
	property p_rtsClr;
		wrDone && paddr == `UISM_OFF_HSCLR && pwdata[0] |=> rtsPin_n;
	endproperty
	a_rtsClr: assert property (p_rtsClr)
		else $error("handshake output not negated");
	property p_rtsKeep;
		wrDone && !pwdata[0] && (paddr == `UISM_OFF_HSSET
			|| paddr == `UISM_OFF_HSCLR) |=> $stable(rtsPin_n);
	endproperty
	a_rtsKeep: assert property (p_rtsKeep)
		else $error("zero write moved handshake output");
	property p_baudHi;
		wrDone && paddr == `UISM_OFF_BAUDH
			|=> baudPreload[15:8] == $past(pwdata[7:0]);
	endproperty
	a_baudHi: assert property (p_baudHi)
		else $error("preload high byte wrong");
	property p_baudLo;
		wrDone && paddr == `UISM_OFF_BAUDL
			|=> baudPreload[7:0] == $past(pwdata[7:0]);
	endproperty
	a_baudLo: assert property (p_baudLo)
		else $error("preload low byte wrong");
	property p_woRead;
		rdDone && (paddr == `UISM_OFF_BAUDH || paddr == `UISM_OFF_BAUDL)
			|-> prdata == 32'h0;
	endproperty
	a_woRead: assert property (p_woRead)
		else $error("preload contents readable");
	property p_vecRst;
		$rose(rst_n) |-> irqVector == `UISM_IVEC_RST;
	endproperty
	a_vecRst: assert property (p_vecRst)
		else $error("vector reset value wrong");
	property p_auxWr;
		wrDone && paddr == `UISM_OFF_AUXCTL
			|=> auxControl[0] == $past(pwdata[0]);
	endproperty
	a_auxWr: assert property (p_auxWr)
		else $error("input enable not stored");
endmodule : uism_checker
bind uism_core uism_checker i_chk (.clk(clk), .rst_n(rst_n), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.prdata(prdata), .pready(pready), .rtsPin_n(rtsPin_n),
	.irqVector(irqVector), .baudPreload(baudPreload),
	.auxControl(auxControl));
`default_nettype wire

// [testbench/uism_term_model.sv]
`timescale 1ns/10ps
`default_nettype none
// modem that grants send some cycles after a request
module uism_term_model (
	// handshake pins
	input  wire logic       clk,
	input  wire logic       rtsPin_n,
	output logic            ctsPin,
	// reply delay in cycles, zero answers at once
	input  wire logic [3:0] lag
);
	int cnt;
	initial begin
		ctsPin = 1'h1;
		cnt = 0;
	end
	// cts follows rts once the lag has run out
	always @(posedge clk)
		if (ctsPin === rtsPin_n)
			cnt <= 0;
		else if (cnt >= lag) begin
			ctsPin <= rtsPin_n;
			cnt <= 0;
		end else
			cnt <= cnt + 1;
endmodule : uism_term_model
`default_nettype wire

// [testbench/tb.sv]
`timescale 1ns/10ps
`default_nettype none
`include "uism_map.svh"
module tb;
	import uism_pkg::*;
	logic        clk = 1'h0, rst_n = 1'h0;
	logic        psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
	logic [11:0] paddr = 12'h0;
	logic [31:0] pwdata = 32'h0, prdata, r, rv, seed = 32'h6831;
	logic        pready, pslverr, err, ctsPin, rtsPin_n, irqOut;
	logic        serialTick = 1'h0, firstModeRf = 1'h0, breakReset = 1'h0;
	logic [3:0]  lag = 4'h0;
	uism_chan_t  chanIn = '0;
	logic [7:0]  irqVector, auxControl;
	logic [15:0] baudPreload;
	int          num_errors = 0, total_checks = 0, cyc = 0;
	// small filter keeps the change tests short
	uism_core #(.FILT_CYC(12)) i_dut (.clk(clk), .rst_n(rst_n),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .serialTick(serialTick), .chanIn(chanIn),
		.firstModeRf(firstModeRf), .breakReset(breakReset),
		.ctsPin(ctsPin), .rtsPin_n(rtsPin_n), .irqOut(irqOut),
		.irqVector(irqVector), .baudPreload(baudPreload),
		.auxControl(auxControl));
	uism_term_model i_term (.clk(clk), .rtsPin_n(rtsPin_n),
		.ctsPin(ctsPin), .lag(lag));
	always #20 clk = ~clk;
	// serial tick every fourth cycle, hang guard
	always @(posedge clk) begin
		serialTick <= (cyc % 4 == 0);
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			num_errors++;
			test_done();
		end
	end
	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : xs
	task automatic chk(input string nm, input logic [31:0] e, g);
		total_checks++;
		if (g !== e) begin
			num_errors++;
			$display("unexpected %s exp %h got %h", nm, e, g);
		end
	endtask : chk
	// one transfer, held until pready is seen
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'h1;
		// look where the answer has settled, release after the edge
		@(negedge clk);
		while (pready !== 1'h1) begin
			@(posedge clk);
			@(negedge clk);
		end
		r = prdata;
		err = pslverr;
		@(posedge clk);
		psel <= 1'h0;
		penable <= 1'h0;
		@(posedge clk);
	endtask : apb
	task automatic rd(input logic [11:0] a, input logic [31:0] e,
		input string nm);
		apb(1'h0, a, 32'h0);
		chk(nm, e, r);
	endtask : rd
	task automatic test_done();
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : test_done
	// main sequence
	initial begin
		repeat (12) @(posedge clk);
		rst_n <= 1'h1;
		repeat (4) @(posedge clk);
		rd(`UISM_OFF_IVEC, 32'h0F, "vector");
		rd(`UISM_OFF_ISTAT, 32'h0, "status");
		rd(`UISM_OFF_INCHG, 32'h0F, "change");
		$display("test reset done");
		rv = xs();
		apb(1'h1, `UISM_OFF_IVEC, rv);
		rd(`UISM_OFF_IVEC, {24'h0, rv[7:0]}, "vector");
		rv = xs() | 32'h2; // never below the minimum
		apb(1'h1, `UISM_OFF_BAUDH, {24'h0, rv[15:8]});
		apb(1'h1, `UISM_OFF_BAUDL, {24'h0, rv[7:0]});
		chk("preload", {16'h0, rv[15:0]}, {16'h0, baudPreload});
		rd(`UISM_OFF_BAUDH, 32'h0, "preload high");
		rd(`UISM_OFF_BAUDL, 32'h0, "preload low");
		rd(12'hFFC, 32'h0, "unmapped");
		chk("slverr", 32'h1, {31'h0, err});
		$display("test registers done");
		// set 0, set 1, clear 0, clear 1; cts pulse stays under filter
		for (int i = 0; i < 4; i++) begin
			apb(1'h1, i[1] ? `UISM_OFF_HSCLR : `UISM_OFF_HSSET,
				(xs() & 32'hFFFFFFFE) | i[0]);
			chk("rts", 32'((4'h9 >> i) & 4'h1), {31'h0, rtsPin_n});
		end
		rd(`UISM_OFF_INCHG, 32'h0F, "glitch");
		$display("test handshake done");
		lag <= 4'h5;
		apb(1'h1, `UISM_OFF_IMASK, 32'h80);
		apb(1'h1, `UISM_OFF_AUXCTL, 32'h1);
		apb(1'h1, `UISM_OFF_HSSET, 32'h1);
		repeat (30) @(posedge clk);
		chk("irq", 32'h1, {31'h0, irqOut});
		rd(`UISM_OFF_ISTAT, 32'h80, "status");
		rd(`UISM_OFF_INPORT, 32'h0, "inport");
		rd(`UISM_OFF_INCHG, 32'h1E, "change");
		rd(`UISM_OFF_ISTAT, 32'h0, "status");
		rd(`UISM_OFF_INCHG, 32'h0E, "change");
		chk("irq", 32'h0, {31'h0, irqOut});
		apb(1'h1, `UISM_OFF_AUXCTL, 32'h0);
		apb(1'h1, `UISM_OFF_HSCLR, 32'h1);
		repeat (30) @(posedge clk);
		rd(`UISM_OFF_ISTAT, 32'h0, "status");
		rd(`UISM_OFF_INCHG, 32'h1F, "change");
		$display("test change done");
		chanIn <= 4'b0101;
		firstModeRf <= 1'h1;
		apb(1'h1, `UISM_OFF_IMASK, 32'h0);
		rd(`UISM_OFF_ISTAT, 32'h03, "status");
		chk("irq", 32'h0, {31'h0, irqOut});
		firstModeRf <= 1'h0;
		rd(`UISM_OFF_ISTAT, 32'h01, "status");
		apb(1'h1, `UISM_OFF_IMASK, 32'h01);
		// irq is launched on the edge the task ends on
		@(negedge clk);
		chk("irq", 32'h1, {31'h0, irqOut});
		@(posedge clk);
		chanIn <= 4'b1000;
		@(posedge clk);
		chanIn <= 4'b0000;
		rd(`UISM_OFF_ISTAT, 32'h04, "status");
		chk("irq", 32'h0, {31'h0, irqOut});
		breakReset <= 1'h1;
		@(posedge clk);
		breakReset <= 1'h0;
		rd(`UISM_OFF_ISTAT, 32'h0, "status");
		$display("test flags done");
		test_done();
	end
endmodule : tb
`default_nettype wire
